/* File: design/isct_pkg.sv */
// constants, register map and state type for the start trigger block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package isct_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FLAG = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  // control register fields
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_START = 1;
  localparam int unsigned CTRL_STOP = 2;
  localparam int unsigned CTRL_EXIT = 3;
  // controller flag register fields
  localparam int unsigned FLAG_RSV_DIS = 0;
  localparam int unsigned FLAG_BUSY = 1;
  localparam int unsigned FLAG_SCF = 7;
  // interrupt status and mask fields
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_STARTED = 0;
  localparam int unsigned IRQ_REFUSED = 1;
  localparam int unsigned IRQ_ARBLOST = 2;
  // status register fields
  localparam int unsigned STAT_PEND = 0;
  localparam int unsigned STAT_MASTER = 1;
  localparam int unsigned STAT_BUSY_OTHER = 2;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_BUF_NS = 4700;
  localparam int unsigned T_SU_STA_NS = 4700;
  localparam int unsigned T_HD_STA_NS = 4000;
  localparam int unsigned T_LOW_NS = 4700;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] BUF_CYC =
    CNT_W'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SU_STA_CYC =
    CNT_W'((T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HD_STA_CYC =
    CNT_W'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LOW_CYC =
    CNT_W'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // start sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BUF,
    ST_RS_LOW,
    ST_RS_HIGH,
    ST_FALL,
    ST_HOLD
  } isct_state_t;
endpackage

/* File: design/isct_sync.sv */
// two-flop synchroniser for bus pin inputs
module isct_sync #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      // idle bus level is high, so reset to high
      always_ff @(posedge mclk) begin
        if (rst) begin
          meta_q <= 1'h1;
          sync_o[i] <= 1'h1;
        end else begin
          meta_q <= async_i[i];
          sync_o[i] <= meta_q;
        end
      end
    end
  endgenerate
endmodule

/* File: design/isct_top.sv */
// start condition trigger with avalon-mm registers and open-drain pins
module isct_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // from the controller's transfer logic
  input wire logic arb_lost_i,
  input wire logic master_wait_i,
  input wire logic wait_release_i,
  // to the controller's transfer logic
  output logic start_done_o,
  output logic master_o,
  output logic irq,
  // two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  //--------------------------------------------------------------------
  // declarations
  //--------------------------------------------------------------------
  isct_pkg::isct_state_t state_q;
  logic [isct_pkg::CNT_W-1:0] cnt_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic en_q;
  logic trig_q;
  logic rsv_dis_q;
  logic scf_q;
  logic busy_q;
  logic master_q;
  logic sda_p_q;
  logic [isct_pkg::IRQ_W-1:0] irq_stat_q;
  logic [isct_pkg::IRQ_W-1:0] irq_mask_q;
  logic [isct_pkg::IRQ_W-1:0] irq_ev;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wr_acc;
  logic ctrl_wr;
  logic start_wr;
  logic exit_wr;
  logic refuse;
  logic busy_other;
  logic start_det;
  logic stop_det;
  logic go_start;
  logic go_rs;
  logic start_done;
  logic halt;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  function automatic logic cnt_end(input logic [isct_pkg::CNT_W-1:0] c,
                                   input logic [isct_pkg::CNT_W-1:0] lim);
    return c == lim - isct_pkg::CNT_W'(1);
  endfunction

  //--------------------------------------------------------------------
  // pin sampling and bus condition detection
  //--------------------------------------------------------------------
  isct_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_p_q <= 1'h1;
    end else begin
      sda_p_q <= sda_s;
    end
  end

  assign start_det = scl_s && sda_p_q && !sda_s;
  assign stop_det = scl_s && !sda_p_q && sda_s;

  //--------------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the answer
  //--------------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign wr_acc = ack_q && avs_write && avs_byteenable[0];
  assign ctrl_wr = wr_acc && hit(avs_address, isct_pkg::OFF_CTRL);
  // a start write that also sets stop is dropped rather than guessed at
  assign start_wr = ctrl_wr && avs_writedata[isct_pkg::CTRL_EN]
                    && avs_writedata[isct_pkg::CTRL_START]
                    && !avs_writedata[isct_pkg::CTRL_STOP];
  assign exit_wr = ctrl_wr && avs_writedata[isct_pkg::CTRL_EXIT];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (hit(avs_address, isct_pkg::OFF_CTRL)) begin
      rd_mux[isct_pkg::CTRL_EN] = en_q;
      // trigger never reads back as one; poll the status register
      rd_mux[isct_pkg::CTRL_START] = 1'h0;
    end else if (hit(avs_address, isct_pkg::OFF_FLAG)) begin
      rd_mux[isct_pkg::FLAG_RSV_DIS] = rsv_dis_q;
      rd_mux[isct_pkg::FLAG_BUSY] = busy_q;
      rd_mux[isct_pkg::FLAG_SCF] = scf_q;
    end else if (hit(avs_address, isct_pkg::OFF_IRQ_STAT)) begin
      rd_mux[isct_pkg::IRQ_W-1:0] = irq_stat_q;
    end else if (hit(avs_address, isct_pkg::OFF_IRQ_MASK)) begin
      rd_mux[isct_pkg::IRQ_W-1:0] = irq_mask_q;
    end else if (hit(avs_address, isct_pkg::OFF_STATUS)) begin
      rd_mux[isct_pkg::STAT_PEND] = trig_q;
      rd_mux[isct_pkg::STAT_MASTER] = master_q;
      rd_mux[isct_pkg::STAT_BUSY_OTHER] = busy_other;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  //--------------------------------------------------------------------
  // control and flag registers
  //--------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_q <= 1'h0;
    end else if (ctrl_wr) begin
      en_q <= avs_writedata[isct_pkg::CTRL_EN];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsv_dis_q <= 1'h0;
    end else if (wr_acc && hit(avs_address, isct_pkg::OFF_FLAG)) begin
      rsv_dis_q <= avs_writedata[isct_pkg::FLAG_RSV_DIS];
    end
  end

  assign busy_other = busy_q && !master_q;
  assign refuse = start_wr && en_q && busy_other && rsv_dis_q;

  // start clear flag: write one clears, a refusal in that cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      scf_q <= 1'h0;
    end else if (refuse) begin
      scf_q <= 1'h1;
    end else if (wr_acc && hit(avs_address, isct_pkg::OFF_FLAG)
                 && avs_writedata[isct_pkg::FLAG_SCF]) begin
      scf_q <= 1'h0;
    end
  end

  //--------------------------------------------------------------------
  // start trigger
  //--------------------------------------------------------------------
  assign halt = !en_q || arb_lost_i || exit_wr;

  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_q <= 1'h0;
    end else if (halt || start_done) begin
      trig_q <= 1'h0;
    end else if (start_wr) begin
      // reservation: the bit stays set until the bus frees up and the start is done
      trig_q <= !(busy_other && rsv_dis_q);
    end
  end

  //--------------------------------------------------------------------
  // bus busy and master state
  //--------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || !en_q) begin
      busy_q <= 1'h0;
    end else if (start_det) begin
      busy_q <= 1'h1;
    end else if (stop_det) begin
      busy_q <= 1'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || halt || stop_det) begin
      master_q <= 1'h0;
    end else if (start_done) begin
      master_q <= 1'h1;
    end
  end

  //--------------------------------------------------------------------
  // start sequencer
  //--------------------------------------------------------------------
  assign go_start = trig_q && !master_q && !busy_q;
  assign go_rs = trig_q && master_q && master_wait_i && wait_release_i;
  assign start_done = (state_q == isct_pkg::ST_FALL)
                      && cnt_end(cnt_q, isct_pkg::HD_STA_CYC);

  always_ff @(posedge mclk) begin
    if (rst || halt) begin
      state_q <= isct_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        isct_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (go_rs) begin
            state_q <= isct_pkg::ST_RS_LOW;
          end else if (go_start) begin
            state_q <= isct_pkg::ST_BUF;
          end
        end
        isct_pkg::ST_BUF: begin
          if (busy_other) begin
            state_q <= isct_pkg::ST_IDLE;
            cnt_q <= '0;
          end else if (!(scl_s && sda_s)) begin
            cnt_q <= '0;
          end else if (cnt_end(cnt_q, isct_pkg::BUF_CYC)) begin
            state_q <= isct_pkg::ST_FALL;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + isct_pkg::CNT_W'(1);
          end
        end
        isct_pkg::ST_RS_LOW: begin
          if (cnt_end(cnt_q, isct_pkg::LOW_CYC)) begin
            state_q <= isct_pkg::ST_RS_HIGH;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + isct_pkg::CNT_W'(1);
          end
        end
        isct_pkg::ST_RS_HIGH: begin
          // a slave stretching the clock holds the count at zero
          if (!(scl_s && sda_s)) begin
            cnt_q <= '0;
          end else if (cnt_end(cnt_q, isct_pkg::SU_STA_CYC)) begin
            state_q <= isct_pkg::ST_FALL;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + isct_pkg::CNT_W'(1);
          end
        end
        isct_pkg::ST_FALL: begin
          if (start_done) begin
            state_q <= isct_pkg::ST_HOLD;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + isct_pkg::CNT_W'(1);
          end
        end
        isct_pkg::ST_HOLD: begin
          if (wait_release_i && trig_q) begin
            state_q <= isct_pkg::ST_RS_LOW;
          end else if (wait_release_i) begin
            state_q <= isct_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= isct_pkg::ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // data low only in fall and hold; clock low in hold and restart low
  assign sda_oe = (state_q == isct_pkg::ST_FALL)
                  || (state_q == isct_pkg::ST_HOLD);
  assign scl_oe = (state_q == isct_pkg::ST_HOLD)
                  || (state_q == isct_pkg::ST_RS_LOW);
  assign sda_o = 1'h0;
  assign scl_o = 1'h0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      start_done_o <= 1'h0;
    end else begin
      start_done_o <= start_done;
    end
  end
  assign master_o = master_q;

  //--------------------------------------------------------------------
  // interrupts
  //--------------------------------------------------------------------
  assign irq_ev = {arb_lost_i && master_q, refuse, start_done};

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else if (wr_acc && hit(avs_address, isct_pkg::OFF_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~avs_writedata[isct_pkg::IRQ_W-1:0])
                    | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_mask_q <= '0;
    end else if (wr_acc && hit(avs_address, isct_pkg::OFF_IRQ_MASK)) begin
      irq_mask_q <= avs_writedata[isct_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  //--------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_rs_low;
    (scl_oe && !sda_oe)[*8];
  endsequence
  sequence s_fall_hold;
    (sda_oe && !scl_oe)[*8];
  endsequence

  a_fall_needs_trig: assert property (
    $rose(sda_oe) |-> $past(trig_q))
    else $error("data pulled low without a start trigger");
  a_free_bus_start: assert property (
    state_q == isct_pkg::ST_IDLE && trig_q && !master_q && !busy_q
    && !halt |=> state_q == isct_pkg::ST_BUF)
    else $error("free bus start not begun");
  a_resv_keeps_trig: assert property (
    state_q == isct_pkg::ST_BUF && busy_other && !halt
    |=> state_q == isct_pkg::ST_IDLE && trig_q)
    else $error("reservation lost while bus busy");
  a_refuse_sets_scf: assert property (
    refuse |=> !trig_q && scf_q)
    else $error("refused start did not set clear flag");
  a_restart_seq: assert property (
    ((go_rs && state_q == isct_pkg::ST_IDLE)
    || (state_q == isct_pkg::ST_HOLD && wait_release_i && trig_q))
    && !halt |=> s_rs_low)
    else $error("repeated start low phase wrong");
  a_done_clears: assert property (
    start_done || arb_lost_i |=> !trig_q)
    else $error("trigger not cleared after start or loss");
  a_exit_clears: assert property (
    exit_wr || !en_q |=> !trig_q)
    else $error("trigger not cleared by exit or disable");
  a_disable_idle: assert property (
    !en_q |=> state_q == isct_pkg::ST_IDLE && !sda_oe && !scl_oe)
    else $error("sequencer active while disabled");
  a_ctrl_read_zero: assert property (
    ack_q && avs_read && hit(avs_address, isct_pkg::OFF_CTRL)
    |-> !avs_readdata[isct_pkg::CTRL_START])
    else $error("start trigger read back as one");
  a_flag_scf_bit: assert property (
    ack_q && avs_read && hit(avs_address, isct_pkg::OFF_FLAG)
    |-> avs_readdata[isct_pkg::FLAG_SCF] == $past(scf_q))
    else $error("clear flag not at its bit");
  a_start_shape: assert property (
    $rose(sda_oe) |-> (scl_s and s_fall_hold))
    else $error("start not formed with clock high");
endmodule

/* File: bench/isct_bus_model.sv */
// model of another master sharing the two-wire bus, with pull-ups
module isct_bus_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench request: occupy the bus as another master
  input wire logic hold_bus,
  // device pin enables
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  // resolved wire levels
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  //----------------------------------------------------------------------
  // wire resolution
  //----------------------------------------------------------------------
  logic own_scl_low_q;
  logic own_sda_low_q;
  logic [2:0] div_q;
  logic [1:0] st_q;
  // pull-ups: a released line reads high, never its last driven value
  assign scl = !(dut_scl_oe || own_scl_low_q);
  assign sda = !(dut_sda_oe || own_sda_low_q);
  //----------------------------------------------------------------------
  // other master: start, clock at 400 ns while holding, then stop
  //----------------------------------------------------------------------
  // the clock stands still outside a frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= 2'h0;
      div_q <= 3'h0;
      own_scl_low_q <= 1'b0;
      own_sda_low_q <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      case (st_q)
        2'h0: if (hold_bus && div_q == 3'h7) begin
          own_sda_low_q <= 1'b1;
          st_q <= 2'h1;
        end
        2'h1: if (div_q[1:0] == 2'h3) begin
          if (!hold_bus && own_scl_low_q) begin
            own_scl_low_q <= 1'b0;
            st_q <= 2'h2;
          end else begin
            own_scl_low_q <= !own_scl_low_q;
          end
        end
        default: if (div_q[1:0] == 2'h3) begin
          own_sda_low_q <= 1'b0;
          st_q <= 2'h0;
        end
      endcase
    end
  end
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the start condition trigger block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  //----------------------------------------------------------------------
  // signals
  //----------------------------------------------------------------------
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] EN = 32'h1 << isct_pkg::CTRL_EN;
  localparam logic [31:0] GO = EN | (32'h1 << isct_pkg::CTRL_START);
  localparam logic [31:0] QUIT = EN | (32'h1 << isct_pkg::CTRL_EXIT);
  localparam logic [31:0] PEND = 32'h1 << isct_pkg::STAT_PEND;
  localparam logic [31:0] BUSY = 32'h1 << isct_pkg::FLAG_BUSY;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic arb_lost_i, master_wait_i, wait_release_i;
  logic start_done_o, master_o, irq, hold_bus, sda_oe_p;
  logic scl, sda, scl_o, scl_oe, sda_o, sda_oe;
  int error_cnt, checks, starts, cycles;

  isct_top i_isct_top (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .arb_lost_i(arb_lost_i), .master_wait_i(master_wait_i),
    .wait_release_i(wait_release_i), .start_done_o(start_done_o),
    .master_o(master_o), .irq(irq), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  isct_bus_model i_isct_bus_model (.mclk(mclk), .rst(rst),
    .hold_bus(hold_bus), .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe),
    .scl(scl), .sda(sda));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  //----------------------------------------------------------------------
  // start counter and timeout
  //----------------------------------------------------------------------
  // only a data fall with the clock wire high counts as a start
  always @(posedge mclk) begin
    sda_oe_p <= sda_oe;
    if (sda_oe === 1'b1 && sda_oe_p === 1'b0 && scl === 1'b1) starts++;
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t timeout", $time);
      final_report;
    end
  end
  //----------------------------------------------------------------------
  // tasks
  //----------------------------------------------------------------------
  task final_report;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one avalon transfer; waitrequest is read as sampled at the edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd & m, exp, what);
  endtask
  task wait_start;
    @(posedge mclk);
    while (start_done_o !== 1'b1) @(posedge mclk);
    cyc(2);
  endtask
  task pulse_release;
    wait_release_i <= 1'b1;
    @(posedge mclk);
    wait_release_i <= 1'b0;
  endtask
  task restart_ctrl;
    bus(1'b1, isct_pkg::OFF_CTRL, 32'h0);
    bus(1'b1, isct_pkg::OFF_CTRL, EN);
    bus(1'b1, isct_pkg::OFF_IRQ_STAT, 32'h7);
  endtask
  //----------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, arb_lost_i, master_wait_i} = 4'h0;
    {wait_release_i, hold_bus, sda_oe_p} = 3'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    {error_cnt, checks, starts, cycles} = {4{32'sd0}};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // reset values, the last address is unmapped
    for (int i = 0; i < 6; i++) rd_chk(5'(i * 4), ALL, 32'h0, "reset");
    bus(1'b1, isct_pkg::OFF_CTRL, EN);
    cyc(150);
    chk(32'(starts), 32'h0, "start without trigger");
    bus(1'b1, isct_pkg::OFF_CTRL, GO & ~EN);
    rd_chk(isct_pkg::OFF_STATUS, PEND, 32'h0, "pending while off");
    cyc(250);
    chk(32'(starts), 32'h0, "start while off");
    // plain start on a free bus
    bus(1'b1, isct_pkg::OFF_CTRL, EN);
    bus(1'b1, isct_pkg::OFF_IRQ_MASK, 32'h7);
    bus(1'b1, isct_pkg::OFF_CTRL, GO);
    rd_chk(isct_pkg::OFF_CTRL, GO, EN, "trigger readback");
    rd_chk(isct_pkg::OFF_STATUS, PEND, PEND, "pending");
    wait_start;
    chk(32'(starts), 32'h1, "one start");
    chk({31'h0, master_o}, 32'h1, "master");
    chk({29'h0, scl_oe, scl_o, sda_o}, 32'h4, "clock held after start");
    rd_chk(isct_pkg::OFF_STATUS, PEND, 32'h0, "auto clear");
    rd_chk(isct_pkg::OFF_IRQ_STAT, ALL, 32'h1, "start event");
    chk({31'h0, irq}, 32'h1, "irq on start");
    bus(1'b1, isct_pkg::OFF_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // repeated start, held back until the wait is released
    master_wait_i <= 1'b1;
    bus(1'b1, isct_pkg::OFF_CTRL, GO);
    cyc(20);
    chk(32'(starts), 32'h1, "restart before release");
    pulse_release;
    wait_start;
    chk(32'(starts), 32'h2, "restart");
    // exit drops a pending restart
    bus(1'b1, isct_pkg::OFF_CTRL, GO);
    bus(1'b1, isct_pkg::OFF_CTRL, QUIT);
    rd_chk(isct_pkg::OFF_STATUS, PEND, 32'h0, "exit clears");
    pulse_release;
    master_wait_i <= 1'b0;
    cyc(300);
    chk(32'(starts), 32'h2, "start after exit");
    restart_ctrl;
    // another master grabs the bus while we wait out the free time
    bus(1'b1, isct_pkg::OFF_CTRL, GO);
    hold_bus <= 1'b1;
    cyc(40);
    rd_chk(isct_pkg::OFF_FLAG, BUSY, BUSY, "busy seen");
    cyc(100);
    rd_chk(isct_pkg::OFF_STATUS, PEND, PEND, "reserved");
    chk(32'(starts), 32'h2, "start on busy bus");
    hold_bus <= 1'b0;
    wait_start;
    chk(32'(starts), 32'h3, "reserved start");
    // arbitration lost while master raises its own event
    arb_lost_i <= 1'b1;
    cyc(1);
    arb_lost_i <= 1'b0;
    rd_chk(isct_pkg::OFF_IRQ_STAT, ALL, 32'h5, "arb lost event");
    bus(1'b1, isct_pkg::OFF_CTRL, QUIT);
    restart_ctrl;
    // reservation disabled: trigger refused, flag set, masked irq
    bus(1'b1, isct_pkg::OFF_IRQ_MASK, 32'h0);
    bus(1'b1, isct_pkg::OFF_FLAG, 32'h01);
    hold_bus <= 1'b1;
    cyc(40);
    bus(1'b1, isct_pkg::OFF_CTRL, GO);
    rd_chk(isct_pkg::OFF_STATUS, PEND, 32'h0, "refused");
    rd_chk(isct_pkg::OFF_FLAG, 32'h83, 32'h83, "clear flag");
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, isct_pkg::OFF_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    bus(1'b1, isct_pkg::OFF_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq acked");
    bus(1'b1, isct_pkg::OFF_FLAG, 32'h81);
    rd_chk(isct_pkg::OFF_FLAG, 32'h81, 32'h01, "flag bits");
    hold_bus <= 1'b0;
    cyc(300);
    chk(32'(starts), 32'h3, "start after refusal");
    // pending trigger dropped by disable, then by lost arbitration
    bus(1'b1, isct_pkg::OFF_FLAG, 32'h0);
    for (int k = 0; k < 2; k++) begin
      hold_bus <= 1'b1;
      cyc(40);
      bus(1'b1, isct_pkg::OFF_CTRL, GO);
      if (k == 0) begin
        bus(1'b1, isct_pkg::OFF_CTRL, 32'h0);
      end else begin
        arb_lost_i <= 1'b1;
        cyc(1);
        arb_lost_i <= 1'b0;
      end
      rd_chk(isct_pkg::OFF_STATUS, PEND, 32'h0, "dropped");
      bus(1'b1, isct_pkg::OFF_CTRL, EN);
      hold_bus <= 1'b0;
      cyc(300);
      chk(32'(starts), 32'h3, "start after drop");
    end
    final_report;
  end
endmodule
